// ===== verilog/dsco_defs.svh
// Constants of the drive state control object bank.
// Function
// - Memory capacity reads as 32 bits, zero when no memory attached.
// - Supply mV, logic mV and board temperature read at subindices 1 to 3.
// - Error code reads as low 16 bits of newest error history entry.
// - Command bit 0 set requests the switched-on state.
// - Command bit 1 set requests the voltage-enabled state.
// - Command bit 2 cleared commands quick stop.
// - Command bit 3 set requests operation enabled.
// - Command bits 4 to 6 and 9 follow the selected operating mode.
// - Command bit 7 clears a pending fault when possible.
// - Command bit 8 halts motion in the five halt-capable modes.
// - State word bit 9 reads one from the first edge after reset; reset clears it with the rest of the word.
// - State word bit 8 shows fieldbus synchronisation.
// - State word bit 15 set only after setup success and index seen.
// - State word bit 11 set when an internal limit is exceeded.
// - Low byte encodes not-ready and switch-on-disabled patterns.
// - Low byte encodes ready, switched-on and operation-enabled patterns.
// - Low byte encodes quick-stop, fault-reaction and fault patterns.
`ifndef DSCO_DEFS_SVH
`define DSCO_DEFS_SVH
`define DSCO_IDX_HW_INFO 16'h4012
`define DSCO_IDX_HW_CFG 16'h4013
`define DSCO_IDX_OPCOND 16'h4014
`define DSCO_IDX_ERR 16'h603f
`define DSCO_IDX_CMD 16'h6040
`define DSCO_IDX_STAT 16'h6041
`define DSCO_SUB_0 8'h00
`define DSCO_SUB_1 8'h01
`define DSCO_SUB_2 8'h02
`define DSCO_SUB_3 8'h03
`define DSCO_HWINFO_MAXSUB 32'h00000001
`define DSCO_HWCFG_MAXSUB 32'h00000001
`define DSCO_OPCOND_MAXSUB 32'h00000003
`define DSCO_CMD_RST 16'h0000
`define DSCO_CFG_RST 32'h00000000
`define DSCO_ERR_RST 16'h0000
`define DSCO_STAT_RST 16'h0000
`define DSCO_CW_SO 0
`define DSCO_CW_EV 1
`define DSCO_CW_QS 2
`define DSCO_CW_EO 3
`define DSCO_CW_OMS_LO 4
`define DSCO_CW_OMS_HI 6
`define DSCO_CW_FR 7
`define DSCO_CW_HALT 8
`define DSCO_CW_OMS_X 9
`define DSCO_SW_VE 4
`define DSCO_SW_WARN 7
`define DSCO_SW_SYNC 8
`define DSCO_SW_REM 9
`define DSCO_SW_CLA 15
`define DSCO_SW_ILA 11
`define DSCO_PAT_NRDY 8'h00
`define DSCO_PAT_SOD 8'h40
`define DSCO_PAT_READY_TO_SWITCH_ON 8'h21
`define DSCO_PAT_SON 8'h23
`define DSCO_PAT_OPEN 8'h27
`define DSCO_PAT_QSA 8'h07
`define DSCO_PAT_FRA 8'h0f
`define DSCO_PAT_FLT 8'h08
`define DSCO_MASK_A 8'h4f
`define DSCO_MASK_B 8'h6f
`define DSCO_MODE_PP 8'h01
`define DSCO_MODE_VL 8'h02
`define DSCO_MODE_PV 8'h03
`define DSCO_MODE_TQ 8'h04
`define DSCO_MODE_IP 8'h07
`endif

// ===== verilog/dsco_pkg.sv
// Types shared by the drive state control object bank.
`default_nettype none
package dsco_pkg;
	typedef enum logic [2:0] {ST_NRDY, ST_SOD, ST_READY_TO_SWITCH_ON, ST_SON, ST_OPEN, ST_QSA, ST_FRA, ST_FLT} dsco_state_e;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [15:0] index;
		logic [7:0] sub;
		logic [31:0] wdata;
	} dsco_req_s;
	typedef struct packed {
		logic valid;
		logic err;
		logic [31:0] rdata;
	} dsco_rsp_s;
	typedef struct packed {
		logic [31:0] supply_mv;
		logic [31:0] logic_mv;
		logic [31:0] temp_dc;
	} dsco_cond_s;
endpackage
`default_nettype wire

// ===== verilog/dsco_top.sv
// Object bank and power state machine of the drive controller.
`timescale 1ns/1ps
`default_nettype none
`include "dsco_defs.svh"
module dsco_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire dsco_pkg::dsco_req_s obj_req,
	output var dsco_pkg::dsco_rsp_s obj_rsp,
	input wire dsco_pkg::dsco_cond_s cond,
	input wire logic nvm_present,
	input wire logic [31:0] nvm_capacity,
	input wire logic [31:0] err_newest,
	input wire logic self_test_done,
	input wire logic fault_event,
	input wire logic fault_clearable,
	input wire logic quick_stop_done,
	input wire logic voltage_present,
	input wire logic warning,
	input wire logic fieldbus_sync,
	input wire logic goal_reached_flag,
	input wire logic internal_limit_flag,
	input wire logic autosetup_ok,
	input wire logic index_seen,
	input wire logic [7:0] op_mode,
	input wire logic [1:0] mode_status,
	output var dsco_pkg::dsco_state_e drive_state,
	output logic [15:0] drive_state_word,
	output logic [15:0] drive_command_word,
	output logic [31:0] hw_config,
	output logic power_stage_on,
	output logic halt_motion,
	output logic [3:0] mode_specific_bits,
	output logic [7:0] mode_specific_mode,
	output logic fault_clear
);
	import dsco_pkg::*;

	// ----------------------------------------
	// Object decode
	// ----------------------------------------
	function automatic logic obj_is(input logic [15:0] i, input logic [7:0] s,
		input logic [15:0] ri, input logic [7:0] rs);
		obj_is = (i == ri) && (s == rs);
	endfunction

	function automatic logic [7:0] state_pattern(input dsco_state_e st);
		unique case (st)
			ST_NRDY: state_pattern = `DSCO_PAT_NRDY;
			ST_SOD: state_pattern = `DSCO_PAT_SOD;
			ST_READY_TO_SWITCH_ON: state_pattern = `DSCO_PAT_READY_TO_SWITCH_ON;
			ST_SON: state_pattern = `DSCO_PAT_SON;
			ST_OPEN: state_pattern = `DSCO_PAT_OPEN;
			ST_QSA: state_pattern = `DSCO_PAT_QSA;
			ST_FRA: state_pattern = `DSCO_PAT_FRA;
			ST_FLT: state_pattern = `DSCO_PAT_FLT;
		endcase
	endfunction

	dsco_rsp_s rsp_reg, rsp_next;
	dsco_state_e state_reg, state_next;
	logic [15:0] cw_reg, cw_next;
	logic [31:0] cfg_reg, cfg_next;
	logic [15:0] err_reg;
	logic [15:0] sw_reg, sw_next;
	logic fr_prev_reg;
	logic power_reg, halt_reg, clear_reg;
	logic [3:0] oms_reg;
	logic [7:0] oms_mode_reg;

	wire [15:0] ri = obj_req.index;
	wire [7:0] rs = obj_req.sub;
	wire req_any = obj_req.rd | obj_req.wr;
	wire k_inf0 = obj_is(ri, rs, `DSCO_IDX_HW_INFO, `DSCO_SUB_0);
	wire k_cap = obj_is(ri, rs, `DSCO_IDX_HW_INFO, `DSCO_SUB_1);
	wire k_cfg0 = obj_is(ri, rs, `DSCO_IDX_HW_CFG, `DSCO_SUB_0);
	wire k_cfg1 = obj_is(ri, rs, `DSCO_IDX_HW_CFG, `DSCO_SUB_1);
	wire k_op0 = obj_is(ri, rs, `DSCO_IDX_OPCOND, `DSCO_SUB_0);
	wire k_sup = obj_is(ri, rs, `DSCO_IDX_OPCOND, `DSCO_SUB_1);
	wire k_lgc = obj_is(ri, rs, `DSCO_IDX_OPCOND, `DSCO_SUB_2);
	wire k_tmp = obj_is(ri, rs, `DSCO_IDX_OPCOND, `DSCO_SUB_3);
	wire k_err = obj_is(ri, rs, `DSCO_IDX_ERR, `DSCO_SUB_0);
	wire k_cmd = obj_is(ri, rs, `DSCO_IDX_CMD, `DSCO_SUB_0);
	wire k_stat = obj_is(ri, rs, `DSCO_IDX_STAT, `DSCO_SUB_0);
	wire mapped = |{k_inf0, k_cap, k_cfg0, k_cfg1, k_op0, k_sup, k_lgc, k_tmp, k_err, k_cmd, k_stat};
	wire writable = k_cfg1 | k_cmd;
	// Only the command word and the configuration entry accept data; others drop it.
	wire wr_cmd = obj_req.wr & k_cmd;
	wire wr_cfg = obj_req.wr & k_cfg1;
	wire [31:0] cap_val = nvm_present ? nvm_capacity : 32'h00000000;
	wire [31:0] rd_val =
		k_inf0 ? `DSCO_HWINFO_MAXSUB :
		k_cap ? cap_val :
		k_cfg0 ? `DSCO_HWCFG_MAXSUB :
		k_cfg1 ? cfg_reg :
		k_op0 ? `DSCO_OPCOND_MAXSUB :
		k_sup ? cond.supply_mv :
		k_lgc ? cond.logic_mv :
		k_tmp ? cond.temp_dc :
		k_err ? {16'h0000, err_reg} :
		k_cmd ? {16'h0000, cw_reg} :
		k_stat ? {16'h0000, sw_reg} : 32'h00000000;

	assign rsp_next.valid = req_any;
	assign rsp_next.err = req_any & (~mapped | (obj_req.wr & ~writable));
	assign rsp_next.rdata = obj_req.rd ? rd_val : 32'h00000000;
	assign cw_next = wr_cmd ? obj_req.wdata[15:0] : cw_reg;
	assign cfg_next = wr_cfg ? obj_req.wdata : cfg_reg;

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	wire so = cw_reg[`DSCO_CW_SO];
	wire ev = cw_reg[`DSCO_CW_EV];
	wire qs = cw_reg[`DSCO_CW_QS];
	wire eo = cw_reg[`DSCO_CW_EO];
	wire fr = cw_reg[`DSCO_CW_FR];
	wire fr_rise = fr & ~fr_prev_reg;
	// Fault reset acts on the rising edge so a held bit cannot mask a new fault.
	wire do_clear = (state_reg == ST_FLT) & fr_rise & fault_clearable;
	wire in_fault = (state_reg == ST_FRA) | (state_reg == ST_FLT);

	always_comb begin
		state_next = state_reg;
		if (fault_event && !in_fault) begin
			state_next = ST_FRA;
		end else begin
			unique case (state_reg)
				ST_NRDY: if (self_test_done) state_next = ST_SOD;
				ST_SOD: if (ev && qs && !so) state_next = ST_READY_TO_SWITCH_ON;
				ST_READY_TO_SWITCH_ON: begin
					if (!ev || !qs) state_next = ST_SOD;
					else if (so) state_next = ST_SON;
				end
				ST_SON: begin
					if (!ev || !qs) state_next = ST_SOD;
					else if (!so) state_next = ST_READY_TO_SWITCH_ON;
					else if (eo) state_next = ST_OPEN;
				end
				ST_OPEN: begin
					if (!ev) state_next = ST_SOD;
					else if (!qs) state_next = ST_QSA;
					else if (!so) state_next = ST_READY_TO_SWITCH_ON;
					else if (!eo) state_next = ST_SON;
				end
				ST_QSA: begin
					if (!ev || quick_stop_done) state_next = ST_SOD;
					else if (qs && so && eo) state_next = ST_OPEN;
				end
				ST_FRA: state_next = ST_FLT;
				ST_FLT: if (do_clear) state_next = ST_SOD;
			endcase
		end
	end

	// ----------------------------------------
	// State word and mode handling
	// ----------------------------------------
	wire closed_loop_ready = autosetup_ok & index_seen;
	wire [7:0] low_byte = state_pattern(state_next)
		| ({7'h00, warning} << `DSCO_SW_WARN) | ({7'h00, voltage_present} << `DSCO_SW_VE);
	assign sw_next = {closed_loop_ready, 1'b0, mode_status, internal_limit_flag, goal_reached_flag,
		1'b1, fieldbus_sync, low_byte};
	wire mode_halts = (op_mode == `DSCO_MODE_PP) | (op_mode == `DSCO_MODE_VL) |
		(op_mode == `DSCO_MODE_PV) | (op_mode == `DSCO_MODE_TQ) | (op_mode == `DSCO_MODE_IP);
	wire halt_next = cw_next[`DSCO_CW_HALT] & mode_halts;
	// Mode bits are passed on with the mode they belong to; their meaning is decided downstream.
	wire [3:0] oms_next = {cw_next[`DSCO_CW_OMS_X], cw_next[`DSCO_CW_OMS_HI:`DSCO_CW_OMS_LO]};

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rsp_reg <= '0;
			cw_reg <= `DSCO_CMD_RST;
			cfg_reg <= `DSCO_CFG_RST;
		end else begin
			rsp_reg <= rsp_next;
			cw_reg <= cw_next;
			cfg_reg <= cfg_next;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= ST_NRDY;
			sw_reg <= `DSCO_STAT_RST;
			err_reg <= `DSCO_ERR_RST;
			fr_prev_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			sw_reg <= sw_next;
			err_reg <= err_newest[15:0];
			fr_prev_reg <= fr;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			power_reg <= 1'b0;
			halt_reg <= 1'b0;
			clear_reg <= 1'b0;
			oms_reg <= 4'h0;
			oms_mode_reg <= 8'h00;
		end else begin
			power_reg <= (state_next == ST_OPEN);
			halt_reg <= halt_next;
			clear_reg <= do_clear;
			oms_reg <= oms_next;
			oms_mode_reg <= op_mode;
		end
	end

	assign obj_rsp = rsp_reg;
	assign drive_state = state_reg;
	assign drive_state_word = sw_reg;
	assign drive_command_word = cw_reg;
	assign hw_config = cfg_reg;
	assign power_stage_on = power_reg;
	assign halt_motion = halt_reg;
	assign mode_specific_bits = oms_reg;
	assign mode_specific_mode = oms_mode_reg;
	assign fault_clear = clear_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	dsco_req_s req_q;
	logic past_ok;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			req_q <= '0;
			past_ok <= 1'b0;
		end else begin
			req_q <= obj_req;
			past_ok <= 1'b1;
		end
	end
	wire q_cap = req_q.rd & obj_is(req_q.index, req_q.sub, `DSCO_IDX_HW_INFO, `DSCO_SUB_1);
	wire q_lgc = req_q.rd & obj_is(req_q.index, req_q.sub, `DSCO_IDX_OPCOND, `DSCO_SUB_2);
	wire q_err = req_q.rd & obj_is(req_q.index, req_q.sub, `DSCO_IDX_ERR, `DSCO_SUB_0);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_nvm_zero;
		past_ok && q_cap && !$past(nvm_present) |-> obj_rsp.rdata == 32'h00000000;
	endproperty
	a_nvm_zero: assert property (p_nvm_zero) else $error("capacity not zero without memory");

	property p_logic_mv;
		past_ok && q_lgc && !req_q.wr |-> obj_rsp.rdata == $past(cond.logic_mv);
	endproperty
	a_logic_mv: assert property (p_logic_mv) else $error("logic voltage readout wrong");

	property p_err_code;
		past_ok && obj_req.rd && !obj_req.wr && k_err ##1 1'b1 |->
			obj_rsp.rdata == {16'h0000, $past(err_newest[15:0], 2)};
	endproperty
	a_err_code: assert property (p_err_code) else $error("error code not newest entry");

	property p_ro_write;
		obj_req.wr && k_stat |=> obj_rsp.valid && obj_rsp.err && $stable(drive_command_word);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write not refused");

	property p_rem;
		past_ok |-> drive_state_word[`DSCO_SW_REM] && (drive_state_word[`DSCO_SW_SYNC] == $past(fieldbus_sync));
	endproperty
	a_rem: assert property (p_rem) else $error("remote or sync bit wrong");

	property p_cla;
		drive_state_word[`DSCO_SW_CLA] |-> $past(autosetup_ok) && $past(index_seen);
	endproperty
	a_cla: assert property (p_cla) else $error("closed loop flag without setup");

	property p_ila;
		past_ok |-> drive_state_word[`DSCO_SW_ILA] == $past(internal_limit_flag);
	endproperty
	a_ila: assert property (p_ila) else $error("limit flag wrong");

	property p_pattern;
		past_ok |-> (drive_state == ST_SOD) == ((drive_state_word[7:0] & `DSCO_MASK_A) == `DSCO_PAT_SOD)
			&& (drive_state == ST_OPEN) == ((drive_state_word[7:0] & `DSCO_MASK_B) == `DSCO_PAT_OPEN)
			&& (drive_state == ST_FLT) == ((drive_state_word[7:0] & `DSCO_MASK_A) == `DSCO_PAT_FLT);
	endproperty
	a_pattern: assert property (p_pattern) else $error("state pattern mismatch");

	sequence s_qs_cmd;
		drive_state == ST_OPEN && drive_command_word[`DSCO_CW_EV] && !drive_command_word[`DSCO_CW_QS] && !fault_event;
	endsequence
	property p_quick_stop;
		s_qs_cmd |=> drive_state == ST_QSA && (drive_state_word[7:0] & `DSCO_MASK_B) == `DSCO_PAT_QSA;
	endproperty
	a_quick_stop: assert property (p_quick_stop) else $error("quick stop not entered");

	sequence s_enable;
		drive_state == ST_SON && drive_command_word[3:0] == 4'hf && !fault_event;
	endsequence
	property p_enable;
		s_enable |=> drive_state == ST_OPEN && power_stage_on;
	endproperty
	a_enable: assert property (p_enable) else $error("operation not enabled");

	sequence s_reset_edge;
		drive_state == ST_FLT && !fault_event && fault_clearable && fr_rise;
	endsequence
	property p_fault_reset;
		s_reset_edge |=> fault_clear && drive_state == ST_SOD ##1 !fault_clear;
	endproperty
	a_fault_reset: assert property (p_fault_reset) else $error("fault not cleared");

	property p_halt;
		halt_motion |-> drive_command_word[`DSCO_CW_HALT] && $past(mode_halts);
	endproperty
	a_halt: assert property (p_halt) else $error("halt outside halt modes");

	property p_oms;
		past_ok |-> mode_specific_bits ==
			{drive_command_word[`DSCO_CW_OMS_X], drive_command_word[`DSCO_CW_OMS_HI:`DSCO_CW_OMS_LO]}
			&& mode_specific_mode == $past(op_mode);
	endproperty
	a_oms: assert property (p_oms) else $error("mode bits not passed");

	property p_start;
		// Checked at the first edge after release; one edge later the state may already have moved on.
		!past_ok |-> drive_state == ST_NRDY && drive_state_word == `DSCO_STAT_RST;
	endproperty
	a_start: assert property (p_start) else $error("not starting in not-ready");
endmodule
`default_nettype wire

// ===== test/dsco_host_model.sv
// Host model that issues object reads and writes to the drive bank.
`timescale 1ns/1ps
`default_nettype none
module dsco_host_model (
	input wire logic clock,
	output var dsco_pkg::dsco_req_s obj_req,
	input wire dsco_pkg::dsco_rsp_s obj_rsp
);
	import dsco_pkg::*;
	initial obj_req = '0;
	// Released index, sub and data fields carry the inverse of their last value and rd and wr drop to zero, so a stale sample cannot pass.
	task automatic access(input logic rd, input logic wr, input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] wd, output logic err, output logic [31:0] rdata, output logic ok);
		int n;
		@(negedge clock);
		obj_req <= '{rd: rd, wr: wr, index: idx, sub: sub, wdata: wd};
		@(posedge clock);
		@(negedge clock);
		obj_req <= '{rd: 1'b0, wr: 1'b0, index: ~idx, sub: ~sub, wdata: ~wd};
		n = 0;
		while (obj_rsp.valid !== 1'b1 && n < 4) begin
			@(negedge clock);
			n++;
		end
		ok = (obj_rsp.valid === 1'b1);
		err = obj_rsp.err;
		rdata = obj_rsp.rdata;
	endtask
endmodule
`default_nettype wire

// ===== test/test_drive_state_control_objects.sv
// Self-checking bench for the drive state control object bank.
`timescale 1ns/1ps
`default_nettype none
`include "dsco_defs.svh"
module test_drive_state_control_objects;
	import dsco_pkg::*;
	localparam logic [15:0] FMASK [9] = '{16'h10, 16'h80, 16'h100, 16'h400, 16'h800, 16'h1000, 16'h2000, 16'h0, 16'h0};
	localparam logic [7:0] MODES [7] = '{`DSCO_MODE_PP, `DSCO_MODE_VL, `DSCO_MODE_PV, `DSCO_MODE_TQ, `DSCO_MODE_IP,
		8'h05, 8'h06};
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	dsco_req_s obj_req;
	dsco_rsp_s obj_rsp;
	dsco_cond_s cond = '{32'h0000b3b0, 32'h00005dc0, 32'hffffff9c};
	logic nvm_present = 1'b1;
	logic [31:0] err_newest = 32'habcd1234;
	logic self_test_done = 1'b0;
	logic fault_event = 1'b0;
	logic fault_clearable = 1'b0;
	logic quick_stop_done = 1'b0;
	logic [8:0] flg = '0;
	logic [7:0] op_mode = 8'h00;
	dsco_state_e drive_state;
	logic [15:0] drive_state_word;
	logic [15:0] drive_command_word;
	logic [31:0] hw_config;
	logic power_stage_on;
	logic halt_motion;
	logic [3:0] mode_specific_bits;
	logic [7:0] mode_specific_mode;
	logic fault_clear;
	int errors = 0;
	int n_tests = 0;
	int fc_cnt = 0;
	logic e;
	logic ok;
	logic [31:0] d;
	always #5 clock = ~clock;
	always @(negedge clock) begin
		if (fault_clear === 1'b1)
			fc_cnt++;
	end
	dsco_host_model dsco_host_model_inst (.clock(clock), .obj_req(obj_req), .obj_rsp(obj_rsp));
	dsco_top dsco_top_inst (.clock(clock), .rst_n(rst_n), .obj_req(obj_req), .obj_rsp(obj_rsp), .cond(cond),
		.nvm_present(nvm_present), .nvm_capacity(32'h00008000), .err_newest(err_newest),
		.self_test_done(self_test_done), .fault_event(fault_event), .fault_clearable(fault_clearable),
		.quick_stop_done(quick_stop_done), .voltage_present(flg[0]), .warning(flg[1]), .fieldbus_sync(flg[2]),
		.goal_reached_flag(flg[3]), .internal_limit_flag(flg[4]), .mode_status(flg[6:5]), .autosetup_ok(flg[7]),
		.index_seen(flg[8]), .op_mode(op_mode), .drive_state(drive_state), .drive_state_word(drive_state_word),
		.drive_command_word(drive_command_word), .hw_config(hw_config), .power_stage_on(power_stage_on),
		.halt_motion(halt_motion), .mode_specific_bits(mode_specific_bits),
		.mode_specific_mode(mode_specific_mode), .fault_clear(fault_clear));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp, input logic xe);
		dsco_host_model_inst.access(1'b1, 1'b0, idx, sub, 32'h0, e, d, ok);
		chk({31'h0, ok}, 32'h1);
		chk({31'h0, e}, {31'h0, xe});
		if (!xe)
			chk(d, exp);
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd, input logic xe);
		dsco_host_model_inst.access(1'b0, 1'b1, idx, sub, wd, e, d, ok);
		chk({31'h0, ok}, 32'h1);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task automatic cmd(input logic [15:0] w);
		wr(16'h6040, 8'h00, {16'h0, w}, 1'b0);
	endtask
	// The state word is read only after two edges; it lags the command register by one edge.
	task automatic st(input dsco_state_e s, input logic [15:0] w);
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk({29'h0, drive_state}, {29'h0, s});
		rd(16'h6041, 8'h00, {16'h0, 16'h0200 | w}, 1'b0);
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		end_sim;
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		@(negedge clock);
		rst_n = 1'b1;
		st(ST_NRDY, 16'h0000);
		cmd(16'h000f);
		st(ST_NRDY, 16'h0000);
		cmd(16'h0000);
		self_test_done = 1'b1;
		st(ST_SOD, 16'h0040);
		cmd(16'h0006);
		st(ST_READY_TO_SWITCH_ON, 16'h0021);
		cmd(16'h0007);
		st(ST_SON, 16'h0023);
		cmd(16'h000f);
		st(ST_OPEN, 16'h0027);
		chk({31'h0, power_stage_on}, 32'h1);
		cmd(16'h000b);
		st(ST_QSA, 16'h0007);
		chk({31'h0, power_stage_on}, 32'h0);
		cmd(16'h000f);
		st(ST_OPEN, 16'h0027);
		cmd(16'h000b);
		st(ST_QSA, 16'h0007);
		quick_stop_done = 1'b1;
		st(ST_SOD, 16'h0040);
		quick_stop_done = 1'b0;
		$display("test power state walk done");
		fault_event = 1'b1;
		@(negedge clock);
		fault_event = 1'b0;
		chk({29'h0, drive_state}, {29'h0, ST_FRA});
		@(negedge clock);
		chk({29'h0, drive_state}, {29'h0, ST_FLT});
		st(ST_FLT, 16'h0008);
		cmd(16'h0080);
		st(ST_FLT, 16'h0008);
		cmd(16'h0000);
		fault_clearable = 1'b1;
		cmd(16'h0080);
		st(ST_SOD, 16'h0040);
		chk(fc_cnt, 32'h1);
		$display("test fault reset done");
		for (int i = 0; i < 9; i++) begin
			flg = 9'h001 << i;
			st(ST_SOD, 16'h0040 | FMASK[i]);
		end
		flg = 9'h180;
		st(ST_SOD, 16'h8040);
		flg = '0;
		$display("test state word flags done");
		for (int i = 0; i < 7; i++) begin
			op_mode = MODES[i];
			cmd(16'h0180);
			chk({31'h0, halt_motion}, {31'h0, i < 5});
			chk({24'h0, mode_specific_mode}, {24'h0, MODES[i]});
		end
		cmd(16'h0270);
		chk({28'h0, mode_specific_bits}, 32'hf);
		cmd(16'h0050);
		chk({28'h0, mode_specific_bits}, 32'h5);
		chk({16'h0, drive_command_word}, 32'h00000050);
		rd(16'h6040, 8'h00, 32'h00000050, 1'b0);
		$display("test mode bits done");
		rd(16'h4012, 8'h00, 32'h1, 1'b0);
		rd(16'h4012, 8'h01, 32'h00008000, 1'b0);
		nvm_present = 1'b0;
		rd(16'h4012, 8'h01, 32'h0, 1'b0);
		wr(16'h4012, 8'h01, 32'h1, 1'b1);
		rd(16'h4013, 8'h00, 32'h1, 1'b0);
		wr(16'h4013, 8'h01, 32'h5a5a00ff, 1'b0);
		rd(16'h4013, 8'h01, 32'h5a5a00ff, 1'b0);
		chk(hw_config, 32'h5a5a00ff);
		rd(16'h4014, 8'h00, 32'h3, 1'b0);
		rd(16'h4014, 8'h01, 32'h0000b3b0, 1'b0);
		rd(16'h4014, 8'h02, 32'h00005dc0, 1'b0);
		rd(16'h4014, 8'h03, 32'hffffff9c, 1'b0);
		wr(16'h4014, 8'h01, 32'h0, 1'b1);
		rd(16'h4014, 8'h01, 32'h0000b3b0, 1'b0);
		rd(16'h603f, 8'h00, 32'h00001234, 1'b0);
		err_newest = 32'h00008311;
		rd(16'h603f, 8'h00, 32'h00008311, 1'b0);
		wr(16'h603f, 8'h00, 32'h0, 1'b1);
		rd(16'h603f, 8'h00, 32'h00008311, 1'b0);
		wr(16'h6041, 8'h00, 32'hffff, 1'b1);
		rd(16'h6041, 8'h00, 32'h0240, 1'b0);
		rd(16'h4015, 8'h00, 32'h0, 1'b1);
		rd(16'h4014, 8'h04, 32'h0, 1'b1);
		$display("test object map done");
		rst_n = 1'b0;
		repeat (2) @(posedge clock);
		@(negedge clock);
		chk({29'h0, drive_state}, {29'h0, ST_NRDY});
		chk({16'h0, drive_state_word}, 32'h0);
		chk({16'h0, drive_command_word}, 32'h0);
		chk(hw_config, 32'h0);
		rst_n = 1'b1;
		st(ST_SOD, 16'h0040);
		$display("test mid-run reset done");
		end_sim;
	end
endmodule
`default_nettype wire
